// File: design/uep_pkg.sv
// register map, field positions and reset values of the ep0 out/status block
// assumes a 32-bit classic wishbone slave, one register per aligned word
package uep_pkg;
	// register word indices as printed in the device map
	localparam logic [15:0] UEP_IDX_OUT_CFG = 16'hFF82;
	localparam logic [15:0] UEP_IDX_OUT_CNT = 16'hFF83;
	// own choices for registers with no printed index
	localparam logic [15:0] UEP_IDX_FUNC_ADR = 16'hFF93;
	localparam logic [15:0] UEP_IDX_EVT_STA = 16'hFF99;
	localparam logic [15:0] UEP_IDX_EVT_MSK = 16'hFF9A;
	localparam logic [15:0] UEP_IDX_IRQ_STA = 16'hFF9B;
	localparam int UEP_ADR_W = 18;
	// ep0_out_config fields
	localparam int UEP_CFG_IE_BIT = 2;
	localparam int UEP_CFG_STALL_BIT = 3;
	localparam int UEP_CFG_TOG_BIT = 5;
	localparam int UEP_CFG_BMA_BIT = 7;
	// ep0_out_byte_count fields
	localparam int UEP_CNT_BUSY_BIT = 7;
	localparam logic [3:0] UEP_CNT_MAX = 4'h8;
	localparam logic [3:0] UEP_CNT_RST = 4'h0;
	localparam logic UEP_BUSY_RST = 1'b1;
	localparam logic [6:0] UEP_ADR_RST = 7'h00;
	// usb_event_status bit positions
	localparam int UEP_STA_SETUP_OVERWRITE_FLAG = 0;
	localparam int UEP_STA_SETUP = 2;
	localparam int UEP_STA_PORT_POWER_ON_FLAG = 3;
	localparam int UEP_STA_PORT_POWER_OFF_FLAG = 4;
	localparam int UEP_STA_RESUME = 5;
	localparam int UEP_STA_SUSP = 6;
	localparam int UEP_STA_BUSRST = 7;
	localparam logic [7:0] UEP_STA_IMPL = 8'hFD;
	localparam logic [7:0] UEP_STA_RST = 8'h00;
	localparam logic [7:0] UEP_MSK_RST = 8'h00;
	// handshake codes toward the serial engine
	typedef enum logic [1:0] {
		UEP_HS_ACK = 2'b00,
		UEP_HS_NAK = 2'b01,
		UEP_HS_STALL = 2'b10,
		UEP_HS_NONE = 2'b11
	} uep_hs_t;
endpackage

// File: design/uep_ctrl.sv
// ep0 out endpoint registers, function address and usb event status
// assumes: serial engine pulses on core clock, pin-level events unsynced
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ns

// Function
// - completion interrupt only when enable bit set
// - stall bit answers STALL, cleared by hardware
// - toggle flag shows tracked data sequence bit
// - buffer manager serves ep0 out only if allowed
// - count codes nine and above drive o_out_count as eight, read back unchanged
// - buffer flag zero means host out accepted
// - buffer flag one NAKs host out; resets one
// - seven-bit bus address, reset zero, firmware written
// - status flags set by hardware, write-one clears
// - masked flags request the microcontroller interrupt
// - setup overwrite flag on setup over setup
// - setup received flag on setup transaction
// - setup flag NAKs all ep0 in, and ep0 out unless stalled
// - port power-on request sets status bit three
// - port power-off request sets status bit four
// - resume condition sets status bit five
// - global or selective suspend sets bit six
// - bus reset sets bit seven, survives reset
// - mask register bit per status flag position
module uep_ctrl #(
	parameter int SYNC_W = 5
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	// classic wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [uep_pkg::UEP_ADR_W-1:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// serial engine, core clock domain
	input wire logic i_usb_rst,
	input wire logic i_out_tok,
	input wire logic i_in_tok,
	input wire logic i_out_done,
	input wire logic i_out_ok,
	input wire logic i_out_pid1,
	input wire logic [3:0] i_out_len,
	input wire logic i_setup_rx,
	input wire logic i_setup_buf_full,
	input wire logic i_in_busy,
	// bus events from pin side, unsynchronised
	input wire logic i_pwr_on_req,
	input wire logic i_pwr_off_req,
	input wire logic i_resume_det,
	input wire logic i_suspend_det,
	// answers
	output uep_pkg::uep_hs_t o_out_hs,
	output uep_pkg::uep_hs_t o_in_hs,
	output logic o_bm_enable,
	output logic [3:0] o_out_count,
	output logic [6:0] o_func_addr,
	output logic o_ep0_irq,
	output logic o_usb_irq
);
	import uep_pkg::*;

	logic [7:0] sta_r;
	logic [7:0] msk_r;
	logic [6:0] adr_r;
	logic ie_r;
	logic stall_r;
	logic tog_r;
	logic bma_r;
	logic busy_r;
	logic [3:0] cnt_r;
	logic done_r;
	logic [SYNC_W-1:0] s1_r;
	logic [SYNC_W-1:0] s2_r;
	logic [SYNC_W-1:0] s3_r;
	logic [SYNC_W-1:0] lvl_r;
	logic [SYNC_W-1:0] rise;
	logic [7:0] sta_set;
	logic [15:0] idx;
	logic wr;
	logic acc;
	logic [7:0] wbyte;
	logic out_take;
	logic [3:0] cnt_eff;

	// ************************************************************
	// bus decode
	// ************************************************************
	assign acc = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	assign idx = i_wb_adr[UEP_ADR_W-1:2];
	// writes land at the edge where the master sees ack high
	assign wr = i_wb_cyc & i_wb_stb & o_wb_ack & i_wb_we & i_wb_sel[0];
	assign wbyte = i_wb_dat[7:0];
	assign cnt_eff = (cnt_r > UEP_CNT_MAX) ? UEP_CNT_MAX : cnt_r;
	// packet taken only into a free, allowed, unstalled buffer
	assign out_take = i_out_done & i_out_ok & ~busy_r & bma_r & ~stall_r
		& ~sta_r[UEP_STA_SETUP];

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_wb_ack <= 1'b0;
		end else begin
			o_wb_ack <= acc;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_wb_dat <= 32'h0000_0000;
		end else if (acc & ~i_wb_we) begin
			case (idx)
			UEP_IDX_OUT_CFG:
				o_wb_dat <= {24'h000000, bma_r, 1'b0, tog_r, 1'b0,
					stall_r, ie_r, 2'b00};
			UEP_IDX_OUT_CNT:
				o_wb_dat <= {24'h000000, busy_r, 3'b000, cnt_r};
			UEP_IDX_FUNC_ADR:
				o_wb_dat <= {25'h0000000, adr_r};
			UEP_IDX_EVT_STA:
				o_wb_dat <= {24'h000000, sta_r};
			UEP_IDX_EVT_MSK:
				o_wb_dat <= {24'h000000, msk_r};
			UEP_IDX_IRQ_STA:
				o_wb_dat <= {24'h000000, sta_r & msk_r};
			default:
				o_wb_dat <= 32'h0000_0000;
			endcase
		end else begin
			o_wb_dat <= 32'h0000_0000;
		end
	end

	// ************************************************************
	// pin event synchronisers
	// ************************************************************
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			lvl_r <= '0;
		end else begin
			// bit 0 spare; bits 1 to 4 carry the pin events
			s1_r <= {i_suspend_det, i_resume_det, i_pwr_off_req,
				i_pwr_on_req, 1'b0};
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int k = 0; k < SYNC_W; k++) begin
				if (s2_r[k] == s3_r[k]) begin
					lvl_r[k] <= s3_r[k];
				end
			end
		end
	end

	always_comb begin
		for (int k = 0; k < SYNC_W; k++) begin
			rise[k] = (s2_r[k] == s3_r[k]) & s3_r[k] & ~lvl_r[k];
		end
	end

	// ************************************************************
	// usb event status and mask
	// ************************************************************
	always_comb begin
		sta_set = 8'h00;
		sta_set[UEP_STA_SETUP_OVERWRITE_FLAG] = i_setup_rx & i_setup_buf_full;
		sta_set[UEP_STA_SETUP] = i_setup_rx;
		sta_set[UEP_STA_PORT_POWER_ON_FLAG] = rise[1];
		sta_set[UEP_STA_PORT_POWER_OFF_FLAG] = rise[2];
		sta_set[UEP_STA_RESUME] = rise[3];
		sta_set[UEP_STA_SUSP] = rise[4];
		sta_set[UEP_STA_BUSRST] = i_usb_rst;
	end

	// event flags: set beats clear; usb reset sets bit seven but clears none
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sta_r <= UEP_STA_RST;
		end else begin
			sta_r <= (sta_r & ~((wr && idx == UEP_IDX_EVT_STA) ? wbyte
				: 8'h00) | sta_set) & UEP_STA_IMPL;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			msk_r <= UEP_MSK_RST;
		end else if (i_usb_rst) begin
			// usb reset clears the mask but never the flags
			msk_r <= UEP_MSK_RST;
		end else if (wr && idx == UEP_IDX_EVT_MSK) begin
			msk_r <= wbyte & UEP_STA_IMPL;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_usb_irq <= 1'b0;
		end else begin
			o_usb_irq <= |(sta_r & msk_r);
		end
	end

	// ************************************************************
	// function address
	// ************************************************************
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			adr_r <= UEP_ADR_RST;
		end else if (i_usb_rst) begin
			// back to the default address on bus reset
			adr_r <= UEP_ADR_RST;
		end else if (wr && idx == UEP_IDX_FUNC_ADR) begin
			adr_r <= wbyte[6:0];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_func_addr <= UEP_ADR_RST;
		end else begin
			o_func_addr <= adr_r;
		end
	end

	// ************************************************************
	// ep0 out configuration
	// ************************************************************
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ie_r <= 1'b0;
			bma_r <= 1'b0;
		end else if (i_usb_rst) begin
			ie_r <= 1'b0;
			bma_r <= 1'b0;
		end else if (wr && idx == UEP_IDX_OUT_CFG) begin
			ie_r <= wbyte[UEP_CFG_IE_BIT];
			bma_r <= wbyte[UEP_CFG_BMA_BIT];
		end
	end

	// stall: firmware sets, next setup clears; hardware clear wins
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			stall_r <= 1'b0;
		end else if (i_usb_rst || i_setup_rx) begin
			stall_r <= 1'b0;
		end else if (wr && idx == UEP_IDX_OUT_CFG) begin
			stall_r <= wbyte[UEP_CFG_STALL_BIT];
		end
	end

	// setup resets sequence to DATA1 expected for data stage
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tog_r <= 1'b0;
		end else if (i_usb_rst) begin
			tog_r <= 1'b0;
		end else if (i_setup_rx) begin
			tog_r <= 1'b1;
		end else if (out_take && i_out_pid1 == tog_r) begin
			tog_r <= ~tog_r;
		end
	end

	// ************************************************************
	// ep0 out byte count and buffer flag
	// ************************************************************
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			busy_r <= UEP_BUSY_RST;
			cnt_r <= UEP_CNT_RST;
		end else if (i_usb_rst) begin
			busy_r <= UEP_BUSY_RST;
			cnt_r <= UEP_CNT_RST;
		end else if (out_take && i_out_pid1 == tog_r) begin
			busy_r <= 1'b1;
			// lengths above eight stored as eight
			cnt_r <= (i_out_len > UEP_CNT_MAX) ? UEP_CNT_MAX : i_out_len;
		end else if (wr && idx == UEP_IDX_OUT_CNT) begin
			busy_r <= wbyte[UEP_CNT_BUSY_BIT];
			cnt_r <= wbyte[3:0];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_out_count <= UEP_CNT_RST;
			o_bm_enable <= 1'b0;
		end else begin
			o_out_count <= cnt_eff;
			o_bm_enable <= bma_r;
		end
	end

	// ************************************************************
	// handshake selection and completion interrupt
	// ************************************************************
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_out_hs <= UEP_HS_NONE;
			o_in_hs <= UEP_HS_NONE;
		end else begin
			// stall outranks every out nak cause; in never stalls
			if (!i_out_tok) begin
				o_out_hs <= UEP_HS_NONE;
			end else if (stall_r) begin
				o_out_hs <= UEP_HS_STALL;
			end else if (sta_r[UEP_STA_SETUP] || busy_r || !bma_r) begin
				o_out_hs <= UEP_HS_NAK;
			end else begin
				o_out_hs <= UEP_HS_ACK;
			end
			if (!i_in_tok) begin
				o_in_hs <= UEP_HS_NONE;
			end else if (sta_r[UEP_STA_SETUP] || i_in_busy) begin
				o_in_hs <= UEP_HS_NAK;
			end else begin
				o_in_hs <= UEP_HS_ACK;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			done_r <= 1'b0;
		end else begin
			// duplicates complete too; only the enable gates
			done_r <= out_take & ie_r;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_ep0_irq <= 1'b0;
		end else begin
			o_ep0_irq <= done_r;
		end
	end
endmodule

// File: tb/uep_ctrl_properties.sv
// checker: bus answers, handshakes and irq timing of uep_ctrl
// assumes: bound to uep_ctrl, one core clock
`timescale 1ns/1ns
module uep_ctrl_properties
	import uep_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic o_wb_ack,
	input wire logic [31:0] o_wb_dat,
	input wire logic i_usb_rst,
	input wire logic i_out_tok,
	input wire logic i_in_tok,
	input wire logic i_out_done,
	input wire logic i_out_ok,
	input wire logic i_setup_rx,
	input wire uep_pkg::uep_hs_t o_out_hs,
	input wire uep_pkg::uep_hs_t o_in_hs,
	input wire logic [3:0] o_out_count,
	input wire logic [6:0] o_func_addr,
	input wire logic o_ep0_irq
);
	import uep_pkg::*;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	chk_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
		|=> o_wb_ack) else $error("bus request not answered");
	chk_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
		else $error("read data outside ack");
	chk_cnt_range: assert property (o_out_count <= 4'h8)
		else $error("byte count above eight");
	chk_setup_out: assert property (i_setup_rx ##[1:4] $rose(i_out_tok)
		|=> o_out_hs == UEP_HS_NAK) else $error("out not nak after setup");
	chk_setup_in: assert property (i_setup_rx ##[1:10] $rose(i_in_tok)
		|=> o_in_hs == UEP_HS_NAK) else $error("in not nak after setup");
	chk_rst_addr: assert property (i_usb_rst |-> ##2 o_func_addr == 7'h00)
		else $error("address kept over bus reset");
	chk_irq_cause: assert property (o_ep0_irq |-> $past(i_out_done, 2))
		else $error("ep0 irq without packet");
	cover property (o_ep0_irq);
	cover property (o_out_hs == UEP_HS_STALL);
	cover property (i_usb_rst);
endmodule

// File: tb/uep_host_model.sv
// partner: host plus serial engine in front of the ep0 pipe
// assumes: handshake answered within four cycles
`timescale 1ns/1ns
module uep_host_model
	import uep_pkg::*;
(
	input wire logic i_clk,
	input wire uep_pkg::uep_hs_t i_out_hs,
	input wire uep_pkg::uep_hs_t i_in_hs,
	output logic o_out_tok = 1'b0,
	output logic o_in_tok = 1'b0,
	output logic o_out_done = 1'b0,
	output logic o_out_ok = 1'b1,
	output logic o_out_pid1 = 1'b0,
	output logic [3:0] o_out_len = 4'h0,
	output logic o_setup_rx = 1'b0,
	output logic o_setup_full = 1'b0,
	output logic o_in_busy = 1'b0
);
	import uep_pkg::*;
	// data only follows an ack
	task automatic xfer(input logic is_in, p, input logic [3:0] n,
			output uep_hs_t hs);
		hs = UEP_HS_NONE;
		@(posedge i_clk);
		o_in_tok <= is_in;
		o_out_tok <= !is_in;
		for (int k = 0; k < 4 && hs == UEP_HS_NONE; k++) begin
			@(posedge i_clk);
			hs = is_in ? i_in_hs : i_out_hs;
		end
		o_in_tok <= 1'b0;
		o_out_tok <= 1'b0;
		if (!is_in && hs == UEP_HS_ACK) begin
			o_out_done <= 1'b1;
			o_out_pid1 <= p;
			o_out_len <= n;
			@(posedge i_clk);
			o_out_done <= 1'b0;
			o_out_pid1 <= !p;
			o_out_len <= ~n;
		end
	endtask
	task automatic set_ok(input logic v);
		@(posedge i_clk);
		o_out_ok <= v;
	endtask
	task automatic setup(input logic full);
		@(posedge i_clk);
		o_setup_rx <= 1'b1;
		o_setup_full <= full;
		@(posedge i_clk);
		o_setup_rx <= 1'b0;
	endtask
endmodule

// File: tb/usb_ep0_out_and_status_tb_top.sv
// testbench: register bus and ep0 traffic of uep_ctrl
// assumes: uep_host_model stands on the serial side
`timescale 1ns/1ns
module usb_ep0_out_and_status_tb_top;
	import uep_pkg::*;
	logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, urst = 0;
	logic [17:0] adr = '0;
	logic [31:0] wd = '0, rd;
	logic [3:0] ev = '0, len, cnt;
	logic ack, tok, itok, dn, ok, pid, srx, sf, ib, bme, eirq, uirq;
	logic [6:0] fa;
	logic [7:0] q;
	uep_hs_t ohs, ihs, hs;
	int err_count = 0, cmp_count = 0, cn = 0, irqs = 0;
	always #20 clk = ~clk;
	uep_ctrl uut (.i_core_clk(clk), .i_rstn(rstn), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
		.i_wb_dat(wd), .o_wb_dat(rd), .o_wb_ack(ack), .i_usb_rst(urst),
		.i_out_tok(tok), .i_in_tok(itok), .i_out_done(dn), .i_out_ok(ok),
		.i_out_pid1(pid), .i_out_len(len), .i_setup_rx(srx),
		.i_setup_buf_full(sf), .i_in_busy(ib), .i_pwr_on_req(ev[0]),
		.i_pwr_off_req(ev[1]), .i_resume_det(ev[2]),
		.i_suspend_det(ev[3]), .o_out_hs(ohs), .o_in_hs(ihs),
		.o_bm_enable(bme), .o_out_count(cnt), .o_func_addr(fa),
		.o_ep0_irq(eirq), .o_usb_irq(uirq));
	uep_host_model host (.i_clk(clk), .i_out_hs(ohs), .i_in_hs(ihs),
		.o_out_tok(tok), .o_in_tok(itok), .o_out_done(dn), .o_out_ok(ok),
		.o_out_pid1(pid), .o_out_len(len), .o_setup_rx(srx),
		.o_setup_full(sf), .o_in_busy(ib));
	always @(negedge clk) if (eirq === 1'b1) irqs++;
	always @(posedge clk) begin
		cn++;
		if (cn > 5000) begin
			err_count++;
			results();
		end
	end
	task automatic chk(input logic [7:0] s, e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] i,
			input logic [7:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		wd <= {24'h0, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rd[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rc(input logic [15:0] i, input logic [7:0] e);
		bus(1'b0, i, 8'h00);
		chk(q, e);
	endtask
	task automatic t_reset();
		rc(UEP_IDX_OUT_CNT, 8'h80);
		rc(UEP_IDX_OUT_CFG, 8'h00);
		rc(UEP_IDX_EVT_MSK, 8'h00);
		rc(16'h0100, 8'h00);
		bus(1'b1, UEP_IDX_FUNC_ADR, 8'hFF);
		rc(UEP_IDX_FUNC_ADR, 8'h7F);
		chk(fa, 8'h7F);
		$display("test reset done");
	endtask
	task automatic t_out();
		bus(1'b1, UEP_IDX_OUT_CFG, 8'h04);
		bus(1'b1, UEP_IDX_OUT_CNT, 8'h00);
		host.xfer(1'b0, 1'b0, 4'h3, hs);
		chk(hs, UEP_HS_NAK);
		chk(bme, 8'h00);
		bus(1'b1, UEP_IDX_OUT_CFG, 8'h84);
		host.xfer(1'b0, 1'b0, 4'hB, hs);
		chk(hs, UEP_HS_ACK);
		chk(bme, 8'h01);
		rc(UEP_IDX_OUT_CNT, 8'h88);
		chk(cnt, 8'h08);
		rc(UEP_IDX_OUT_CFG, 8'hA4);
		host.xfer(1'b0, 1'b1, 4'h2, hs);
		chk(hs, UEP_HS_NAK);
		bus(1'b1, UEP_IDX_OUT_CFG, 8'h80);
		bus(1'b1, UEP_IDX_OUT_CNT, 8'h00);
		host.xfer(1'b0, 1'b0, 4'h5, hs);
		rc(UEP_IDX_OUT_CNT, 8'h00);
		host.set_ok(1'b0);
		host.xfer(1'b0, 1'b1, 4'h6, hs);
		chk(hs, UEP_HS_ACK);
		rc(UEP_IDX_OUT_CNT, 8'h00);
		host.set_ok(1'b1);
		host.xfer(1'b0, 1'b1, 4'h0, hs);
		rc(UEP_IDX_OUT_CNT, 8'h80);
		rc(UEP_IDX_OUT_CFG, 8'h80);
		chk(8'(irqs), 8'h01);
		bus(1'b1, UEP_IDX_OUT_CNT, 8'h8B);
		rc(UEP_IDX_OUT_CNT, 8'h8B);
		chk(cnt, 8'h08);
		$display("test out done");
	endtask
	task automatic t_setup();
		bus(1'b1, UEP_IDX_OUT_CFG, 8'h88);
		host.xfer(1'b0, 1'b0, 4'h1, hs);
		chk(hs, UEP_HS_STALL);
		bus(1'b1, UEP_IDX_EVT_MSK, 8'hFF);
		rc(UEP_IDX_EVT_MSK, 8'hFD);
		bus(1'b1, UEP_IDX_EVT_MSK, 8'h04);
		host.setup(1'b0);
		host.xfer(1'b0, 1'b1, 4'h1, hs);
		chk(hs, UEP_HS_NAK);
		host.xfer(1'b1, 1'b0, 4'h0, hs);
		chk(hs, UEP_HS_NAK);
		rc(UEP_IDX_OUT_CFG, 8'hA0);
		rc(UEP_IDX_EVT_STA, 8'h04);
		chk(uirq, 8'h01);
		host.setup(1'b1);
		bus(1'b1, UEP_IDX_EVT_STA, 8'h00);
		rc(UEP_IDX_EVT_STA, 8'h05);
		bus(1'b1, UEP_IDX_EVT_STA, 8'h05);
		rc(UEP_IDX_EVT_STA, 8'h00);
		chk(uirq, 8'h00);
		host.xfer(1'b1, 1'b0, 4'h0, hs);
		chk(hs, UEP_HS_ACK);
		$display("test setup done");
	endtask
	task automatic t_events();
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			ev[k] <= 1'b1;
			repeat (12) @(posedge clk);
		end
		urst <= 1'b1;
		@(posedge clk);
		urst <= 1'b0;
		rc(UEP_IDX_EVT_STA, 8'hF8);
		rc(UEP_IDX_FUNC_ADR, 8'h00);
		rc(UEP_IDX_OUT_CNT, 8'h80);
		$display("test events done");
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_out();
		t_setup();
		t_events();
		results();
	end
endmodule
bind uep_ctrl uep_ctrl_properties chk_i (.i_core_clk, .i_rstn, .i_wb_cyc,
	.i_wb_stb, .o_wb_ack, .o_wb_dat, .i_usb_rst, .i_out_tok, .i_in_tok,
	.i_out_done, .i_out_ok, .i_setup_rx, .o_out_hs, .o_in_hs,
	.o_out_count, .o_func_addr, .o_ep0_irq);
